// ===== input_sync_edge.sv
// Two-stage synchroniser with rising and falling edge pulses per input.
module input_sync_edge
   import pwm_timer_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [N_SYNC-1:0] async_in,
   output logic [N_SYNC-1:0] rise,
   output logic [N_SYNC-1:0] fall
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [N_SYNC-1:0] meta;
      logic [N_SYNC-1:0] stable;
      logic [N_SYNC-1:0] prev;
   } sync_state_type;

   sync_state_type s;
   sync_state_type next_s;

   // The first stage feeds only the second; edges are taken later.
   always_comb begin
      next_s = s;
      next_s.meta = async_in;
      next_s.stable = s.meta;
      next_s.prev = s.stable;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Edge pulses, one per bit
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N_SYNC; i++) begin : g_edge
         assign rise[i] = s.stable[i] & ~s.prev[i];
         assign fall[i] = ~s.stable[i] & s.prev[i];
      end
   endgenerate

endmodule : input_sync_edge

// ===== pin_partner.sv
// Pin-side partner of the PWM timer: capture sources, count clock, pin timing.
module pin_partner
   import pwm_timer_pkg::*;
(
   input wire logic aclk,
   input wire logic [N_PWM-1:0] pulse_out_pin,
   output logic [N_CAP-1:0] capture_in_pin,
   output logic ext_count_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   int per_len[N_PWM] = '{default: 0};
   int hi_len[N_PWM] = '{default: 0};
   int per_cnt[N_PWM] = '{default: 0};
   int hi_cnt[N_PWM] = '{default: 0};
   logic [N_PWM-1:0] last = '0;

   // The count clock stands still between bursts, as a real source would.
   initial begin
      capture_in_pin = '0;
      ext_count_clk = 1'b0;
   end

   // ------------------------------------------------------------
   // Pin timing, measured in whole clock cycles between edges.
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      for (int k = 0; k < N_PWM; k++) begin
         if (pulse_out_pin[k] && !last[k]) begin
            per_len[k] = per_cnt[k];
            per_cnt[k] = 1;
            hi_cnt[k] = 1;
         end else begin
            per_cnt[k]++;
            if (pulse_out_pin[k]) hi_cnt[k]++;
         end
         if (!pulse_out_pin[k] && last[k]) hi_len[k] = hi_cnt[k];
      end
      last = pulse_out_pin;
   end

   // Half periods stay well above three cycles so no edge is lost.
   task automatic ext_pulses(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge aclk);
         ext_count_clk <= 1'b1;
         repeat (half) @(posedge aclk);
         ext_count_clk <= 1'b0;
      end
   endtask : ext_pulses

   task automatic cap_set(input int ch, input logic lvl);
      @(posedge aclk);
      capture_in_pin[ch] <= lvl;
   endtask : cap_set
endmodule : pin_partner

// ===== pwm_autoreload_timer_8bit.sv
// Eight-bit auto-reload PWM timer with input capture and AXI4-Lite access.
module pwm_autoreload_timer_8bit
   import pwm_timer_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [N_CAP-1:0] capture_in_pin,
   input wire logic ext_count_clk,
   output logic [N_PWM-1:0] pulse_out_pin,
   output logic [N_PWM-1:0] pulse_out_oe,
   output logic wrap_irq,
   output logic [N_CAP-1:0] capture_irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] count;
      logic [6:0] psc;
      logic [7:0] reload;
      logic [N_PWM-1:0][7:0] duty;
      logic [N_PWM-1:0][7:0] shadow;
      logic [7:0] pctl;
      logic ext_clk_sel;
      logic [2:0] prescale_select;
      logic count_run;
      logic wrap_irq_on;
      logic wrap_flag;
      logic [N_CAP-1:0] sens;
      logic [N_CAP-1:0] capture_irq_on;
      logic [N_CAP-1:0] capture_flag;
      logic [N_CAP-1:0][7:0] captured_count;
      logic awready;
      logic wready;
      logic [IDX_W-1:0] wr_idx;
      logic [7:0] wr_data;
      logic wr_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rd_data;
      logic [1:0] rresp;
      logic [N_PWM-1:0] pin;
      logic [N_PWM-1:0] pin_oe;
      logic wrap_irq;
      logic [N_CAP-1:0] cap_irq;
   } timer_state_type;
   timer_state_type s;
   timer_state_type next_s;
   logic [N_SYNC-1:0] pin_rise;
   logic [N_SYNC-1:0] pin_fall;
   logic in_en;
   logic [6:0] mask;
   logic tick;
   logic wrap_now;
   logic rd_take;
   logic wr_do;
   logic [IDX_W-1:0] rd_idx;
   logic [N_CAP-1:0] cap_evt;
   logic [N_CAP-1:0] rd_cap;

   // ---------------------------------------------------------------
   // Pin input stage
   // ---------------------------------------------------------------
   input_sync_edge u_input_sync_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({ext_count_clk, capture_in_pin}),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   function automatic logic [N_PWM-1:0] pwm_level(
      input logic [7:0] cnt,
      input logic [N_PWM-1:0][7:0] cmp,
      input logic [7:0] ctl
   );
      logic [N_PWM-1:0] lvl;
      lvl = '0;
      for (int k = 0; k < N_PWM; k++) begin
         lvl[k] = ctl[PCTL_OE_LO+k]
            & ((cnt <= cmp[k]) ^ ctl[PCTL_INV_LO+k]);
      end
      return lvl;
   endfunction : pwm_level

   // ---------------------------------------------------------------
   // Counting strobes
   // ---------------------------------------------------------------
   // The external clock is only sampled, so it must be well below aclk.
   assign in_en = s.ext_clk_sel ? pin_rise[SYNC_EXT] : 1'b1;
   assign mask = (PSC_ONE << s.prescale_select) - PSC_ONE;
   assign tick = s.count_run && in_en && ((s.psc & mask) == mask);
   assign wrap_now = tick && (s.count == COUNT_MAX);
   assign rd_idx = araddr[ADDR_W-1:2];
   assign rd_take = arvalid && s.arready;
   assign wr_do = !s.awready && !s.wready && !s.bvalid;
   always_comb begin
      for (int k = 0; k < N_CAP; k++) begin
         cap_evt[k] = s.sens[k] ? pin_rise[k] : pin_fall[k];
      end
      rd_cap[0] = rd_take && (rd_idx == IDX_CAP1);
      rd_cap[1] = rd_take && (rd_idx == IDX_CAP2);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      // Read answer and read side effects come first so sets win.
      if (rd_take) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         case (rd_idx)
            IDX_DUTY3: next_s.rd_data = s.duty[3];
            IDX_DUTY2: next_s.rd_data = s.duty[2];
            IDX_DUTY1: next_s.rd_data = s.duty[1];
            IDX_DUTY0: next_s.rd_data = s.duty[0];
            IDX_PCTL: next_s.rd_data = s.pctl;
            IDX_TCS: begin
               next_s.rd_data = {s.ext_clk_sel, s.prescale_select,
                  s.count_run, 1'b0, s.wrap_irq_on, s.wrap_flag};
               next_s.wrap_flag = 1'b0;
            end
            IDX_COUNT: next_s.rd_data = s.count;
            IDX_RELOAD: next_s.rd_data = s.reload;
            IDX_CCS: next_s.rd_data = {2'b00, s.sens, s.capture_irq_on,
               s.capture_flag};
            IDX_CAP1: next_s.rd_data = s.captured_count[0];
            IDX_CAP2: next_s.rd_data = s.captured_count[1];
            default: begin
               next_s.rd_data = REG_RESET;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end
      for (int k = 0; k < N_CAP; k++) begin
         if (rd_cap[k]) begin
            next_s.capture_flag[k] = 1'b0;
         end
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end
      // Prescaler and counter.
      if (s.count_run && in_en) begin
         next_s.psc = s.psc + PSC_ONE;
      end
      if (tick) begin
         if (wrap_now) begin
            next_s.count = s.reload;
            next_s.wrap_flag = 1'b1;
            next_s.shadow = s.duty;
         end else begin
            next_s.count = s.count + 8'h01;
         end
      end
      // A pending capture blocks the next one until it is read.
      for (int k = 0; k < N_CAP; k++) begin
         if (cap_evt[k] && (!s.capture_flag[k] || rd_cap[k])) begin
            next_s.captured_count[k] = s.count;
            next_s.capture_flag[k] = 1'b1;
         end
      end
      // Write address and data are taken in either order.
      if (awvalid && s.awready) begin
         next_s.awready = 1'b0;
         next_s.wr_idx = awaddr[ADDR_W-1:2];
      end
      if (wvalid && s.wready) begin
         next_s.wready = 1'b0;
         next_s.wr_data = wdata[7:0];
         next_s.wr_lane0 = wstrb[0];
      end
      if (wr_do) begin
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         if (s.wr_idx < IDX_DUTY3 || s.wr_idx > IDX_CAP2) begin
            next_s.bresp = RESP_SLVERR;
         end else if (s.wr_lane0) begin
            case (s.wr_idx)
               IDX_DUTY3: next_s.duty[3] = s.wr_data;
               IDX_DUTY2: next_s.duty[2] = s.wr_data;
               IDX_DUTY1: next_s.duty[1] = s.wr_data;
               IDX_DUTY0: next_s.duty[0] = s.wr_data;
               IDX_PCTL: next_s.pctl = s.wr_data;
               IDX_TCS: begin
                  next_s.ext_clk_sel = s.wr_data[TCS_EXT];
                  next_s.prescale_select = s.wr_data[TCS_PSEL_LO+:3];
                  next_s.count_run = s.wr_data[TCS_RUN];
                  next_s.wrap_irq_on = s.wr_data[TCS_WRAP_ON];
                  if (s.wr_data[TCS_FORCE]) begin
                     next_s.count = s.reload;
                     next_s.psc = '0;
                  end
               end
               IDX_COUNT: begin
                  next_s.count = s.wr_data;
                  next_s.psc = '0;
               end
               IDX_RELOAD: next_s.reload = s.wr_data;
               IDX_CCS: begin
                  next_s.sens = s.wr_data[CCS_SENS_LO+:N_CAP];
                  next_s.capture_irq_on = s.wr_data[CCS_ON_LO+:N_CAP];
               end
               default: next_s.bresp = RESP_OKAY;
            endcase
         end
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end
      // Outputs follow the settled state, so polarity acts at once.
      next_s.pin = pwm_level(next_s.count, next_s.shadow,
         next_s.pctl);
      next_s.pin_oe = next_s.pctl[PCTL_OE_LO+:N_PWM];
      next_s.wrap_irq = next_s.wrap_flag & next_s.wrap_irq_on;
      next_s.cap_irq = next_s.capture_flag
         & next_s.capture_irq_on;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = {24'h000000, s.rd_data};
   assign pulse_out_pin = s.pin;
   assign pulse_out_oe = s.pin_oe;
   assign wrap_irq = s.wrap_irq;
   assign capture_irq = s.cap_irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_frozen;
      @(posedge aclk) disable iff (!aresetn)
      !s.count_run && !wr_do |=> $stable(s.count) && $stable(s.psc);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("Counter moved while stopped.");
   property p_force_zero;
      @(posedge aclk) disable iff (!aresetn)
      rd_take && rd_idx == IDX_TCS |=> s.rd_data[TCS_FORCE] == 1'b0;
   endproperty
   a_force_zero: assert property (p_force_zero)
      else $error("Force reload bit read as one.");
   property p_force_load;
      @(posedge aclk) disable iff (!aresetn)
      wr_do && s.wr_idx == IDX_TCS && s.wr_lane0 && s.wr_data[TCS_FORCE]
      |=> s.count == $past(s.reload) && s.psc == 7'h00;
   endproperty
   a_force_load: assert property (p_force_load)
      else $error("Force reload did not load the counter.");
   property p_wrap_irq;
      @(posedge aclk) disable iff (!aresetn)
      wrap_irq == (s.wrap_flag && s.wrap_irq_on);
   endproperty
   a_wrap_irq: assert property (p_wrap_irq)
      else $error("Wrap request does not match flag and enable.");
   property p_wrap;
      @(posedge aclk) disable iff (!aresetn)
      wrap_now && !wr_do |=> s.wrap_flag && s.count == $past(s.reload);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Overflow did not reload or flag.");
   property p_read_clear;
      @(posedge aclk) disable iff (!aresetn)
      rd_take && rd_idx == IDX_TCS && !wrap_now |=> !s.wrap_flag;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("Status read did not clear the wrap flag.");
   property p_shadow;
      @(posedge aclk) disable iff (!aresetn)
      wrap_now |=> s.shadow == $past(s.duty);
   endproperty
   a_shadow: assert property (p_shadow)
      else $error("Shadow compare not loaded at overflow.");
   property p_shadow_hold;
      @(posedge aclk) disable iff (!aresetn)
      !wrap_now |=> $stable(s.shadow);
   endproperty
   a_shadow_hold: assert property (p_shadow_hold)
      else $error("Shadow compare changed between overflows.");
   property p_pwm;
      @(posedge aclk) disable iff (!aresetn)
      pulse_out_pin == pwm_level(s.count, s.shadow, s.pctl);
   endproperty
   a_pwm: assert property (p_pwm)
      else $error("Pulse output level is wrong.");
   property p_cap_hold;
      @(posedge aclk) disable iff (!aresetn)
      s.capture_flag[0] && !rd_cap[0] |=> $stable(s.captured_count[0]);
   endproperty
   a_cap_hold: assert property (p_cap_hold)
      else $error("Capture value overwritten before read.");
   property p_reserved;
      @(posedge aclk) disable iff (!aresetn)
      rd_take && rd_idx == IDX_CCS |=> s.rd_data[7:6] == 2'b00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("Reserved capture status bits not zero.");

endmodule : pwm_autoreload_timer_8bit

// ===== pwm_autoreload_timer_8bit_tb_top.sv
// Self-checking testbench of the auto-reload PWM timer.
module pwm_autoreload_timer_8bit_tb_top
   import pwm_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, wrap_irq, ext_count_clk;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [N_CAP-1:0] capture_in_pin, capture_irq;
   logic [N_PWM-1:0] pulse_out_pin, pulse_out_oe;
   int err_count = 0;
   int tests_run = 0;
   int mdl[11] = '{default: 0};
   integer seed = 32'he6c4;

   always #5 aclk = ~aclk;

   pwm_autoreload_timer_8bit u_pwm_autoreload_timer_8bit (.aclk(aclk),
      .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .capture_in_pin(capture_in_pin), .ext_count_clk(ext_count_clk),
      .pulse_out_pin(pulse_out_pin), .pulse_out_oe(pulse_out_oe),
      .wrap_irq(wrap_irq), .capture_irq(capture_irq));

   pin_partner u_pin_partner (.aclk(aclk), .pulse_out_pin(pulse_out_pin),
      .capture_in_pin(capture_in_pin), .ext_count_clk(ext_count_clk));

   // ------------------------------------------------------------
   // Checking, bus tasks and the closing report.
   // ------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic hang;
      err_count++;
      $display("ERROR handshake expected answer seen none");
      final_report();
   endtask : hang

   task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] st, input logic [1:0] er);
      bit a_ok;
      bit w_ok;
      int n;
      awaddr <= {idx, 2'b00};
      awvalid <= 1'b1;
      wdata <= {24'h0, d};
      wstrb <= st;
      wvalid <= 1'b1;
      a_ok = 0;
      w_ok = 0;
      for (n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (!a_ok && awready) begin
            a_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
         if (bvalid) break;
      end
      if (n == 60) hang();
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      if (st[0] && er == RESP_OKAY && idx >= IDX_DUTY3 &&
          (idx <= IDX_PCTL || idx == IDX_RELOAD)) mdl[idx - IDX_DUTY3] = d;
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [7:0] exp,
                     input logic [1:0] er);
      bit a_ok;
      int n;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      a_ok = 0;
      for (n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (!a_ok && arready) begin
            a_ok = 1;
            arvalid <= 1'b0;
         end
         if (rvalid) break;
      end
      if (n == 60) hang();
      chk("rdata", rdata, {24'h0, exp});
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask : rd

   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial begin
      int w;
      logic [7:0] pc;
      logic [3:0] base;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         rd(IDX_DUTY3 + 10'(i), 8'h00, RESP_OKAY);
      end
      rd(10'h07F, 8'h00, RESP_SLVERR);
      wr(10'h000, 8'h55, 4'h1, RESP_SLVERR);
      $display("test reset and map done");
      wr(IDX_RELOAD, 8'hF0, 4'h1, RESP_OKAY);
      for (int k = 0; k < N_PWM; k++) begin
         wr(IDX_DUTY0 - 10'(k), 8'(8'hF1 + 2 * k), 4'h1, RESP_OKAY);
      end
      wr(IDX_PCTL, 8'hF0, 4'h1, RESP_OKAY);
      for (int n = 0; n < 8; n++) begin
         wr(IDX_TCS, {1'b0, n[2:0], 4'hC}, 4'h1, RESP_OKAY);
         repeat ((16 << n) * 3 + 8) @(posedge aclk);
         for (int k = 0; k < N_PWM; k++) begin
            chk("period", u_pin_partner.per_len[k], 16 << n);
            chk("high", u_pin_partner.hi_len[k], (2 + 2*k) << n);
         end
      end
      $display("test prescale and pwm done");
      wr(IDX_TCS, 8'h00, 4'h1, RESP_OKAY);
      chk("wrap_irq", wrap_irq, 1'b0);
      rd(IDX_TCS, 8'h01, RESP_OKAY);
      rd(IDX_TCS, 8'h00, RESP_OKAY);
      wr(IDX_COUNT, 8'hFE, 4'h1, RESP_OKAY);
      wr(IDX_TCS, 8'h0A, 4'h1, RESP_OKAY);
      for (w = 0; w < 40 && wrap_irq !== 1'b1; w++) @(posedge aclk);
      if (w == 40) hang();
      chk("wrap_irq", wrap_irq, 1'b1);
      wr(IDX_TCS, 8'h02, 4'h1, RESP_OKAY);
      rd(IDX_TCS, 8'h03, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("wrap_irq", wrap_irq, 1'b0);
      $display("test wrap flag done");
      wr(IDX_COUNT, 8'hF4, 4'h1, RESP_OKAY);
      for (int k = 0; k < N_PWM; k++) base[k] = (8'hF4 <= mdl[3 - k][7:0]);
      for (int i = 0; i < 6; i++) begin
         pc = 8'($random(seed));
         wr(IDX_PCTL, pc, 4'h1, RESP_OKAY);
         chk("pins", pulse_out_pin, pc[7:4] & (base ^ pc[3:0]));
         chk("oe", pulse_out_oe, pc[7:4]);
      end
      wr(IDX_DUTY0, 8'hFF, 4'h1, RESP_OKAY);
      chk("pins", pulse_out_pin, pc[7:4] & (base ^ pc[3:0]));
      rd(IDX_COUNT, 8'hF4, RESP_OKAY);
      rd(IDX_DUTY0, mdl[3][7:0], RESP_OKAY);
      $display("test polarity done");
      wr(IDX_RELOAD, 8'h80, 4'h1, RESP_OKAY);
      wr(IDX_TCS, 8'h04, 4'h1, RESP_OKAY);
      rd(IDX_COUNT, 8'h80, RESP_OKAY);
      rd(IDX_TCS, 8'h00, RESP_OKAY);
      wr(IDX_RELOAD, 8'h33, 4'h0, RESP_OKAY);
      rd(IDX_RELOAD, mdl[7][7:0], RESP_OKAY);
      wr(IDX_COUNT, 8'h10, 4'h1, RESP_OKAY);
      wr(IDX_TCS, 8'h88, 4'h1, RESP_OKAY);
      repeat (10) @(posedge aclk);
      rd(IDX_COUNT, 8'h10, RESP_OKAY);
      u_pin_partner.ext_pulses(5, 5);
      repeat (8) @(posedge aclk);
      rd(IDX_COUNT, 8'h15, RESP_OKAY);
      wr(IDX_TCS, 8'h00, 4'h1, RESP_OKAY);
      $display("test reload and count clock done");
      wr(IDX_CCS, 8'hDF, 4'h1, RESP_OKAY);
      rd(IDX_CCS, 8'h1C, RESP_OKAY);
      u_pin_partner.cap_set(1, 1'b1);
      repeat (6) @(posedge aclk);
      rd(IDX_CCS, 8'h1C, RESP_OKAY);
      u_pin_partner.cap_set(0, 1'b1);
      u_pin_partner.cap_set(1, 1'b0);
      repeat (6) @(posedge aclk);
      chk("capture_irq", capture_irq, 2'b11);
      rd(IDX_CCS, 8'h1F, RESP_OKAY);
      wr(IDX_COUNT, 8'h40, 4'h1, RESP_OKAY);
      u_pin_partner.cap_set(0, 1'b0);
      u_pin_partner.cap_set(0, 1'b1);
      repeat (6) @(posedge aclk);
      rd(IDX_CAP1, 8'h15, RESP_OKAY);
      rd(IDX_CCS, 8'h1E, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("capture_irq", capture_irq, 2'b10);
      wr(IDX_CCS, 8'h14, 4'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("capture_irq", capture_irq, 2'b00);
      wr(IDX_CAP2, 8'h99, 4'h1, RESP_OKAY);
      rd(IDX_CAP2, 8'h15, RESP_OKAY);
      rd(IDX_CCS, 8'h14, RESP_OKAY);
      $display("test capture done");
      final_report();
   end
endmodule : pwm_autoreload_timer_8bit_tb_top

// ===== pwm_timer_pkg.sv
// Constants shared by the auto-reload PWM timer and its input stage.
package pwm_timer_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   localparam logic [9:0] IDX_DUTY3 = 10'h074;
   localparam logic [9:0] IDX_DUTY2 = 10'h075;
   localparam logic [9:0] IDX_DUTY1 = 10'h076;
   localparam logic [9:0] IDX_DUTY0 = 10'h077;
   localparam logic [9:0] IDX_PCTL = 10'h078;
   localparam logic [9:0] IDX_TCS = 10'h079;
   localparam logic [9:0] IDX_COUNT = 10'h07A;
   localparam logic [9:0] IDX_RELOAD = 10'h07B;
   localparam logic [9:0] IDX_CCS = 10'h07C;
   localparam logic [9:0] IDX_CAP1 = 10'h07D;
   localparam logic [9:0] IDX_CAP2 = 10'h07E;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int TCS_EXT = 7;
   localparam int TCS_PSEL_LO = 4;
   localparam int TCS_RUN = 3;
   localparam int TCS_FORCE = 2;
   localparam int TCS_WRAP_ON = 1;
   localparam int TCS_WRAP_FLAG = 0;
   localparam int PCTL_OE_LO = 4;
   localparam int PCTL_INV_LO = 0;
   localparam int CCS_SENS_LO = 4;
   localparam int CCS_ON_LO = 2;
   localparam int CCS_FLAG_LO = 0;

   // ---------------------------------------------------------------
   // Widths, values and bus answers
   // ---------------------------------------------------------------
   localparam int N_PWM = 4;
   localparam int N_CAP = 2;
   localparam int N_SYNC = 3;
   localparam int SYNC_EXT = 2;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [6:0] PSC_ONE = 7'h01;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pwm_timer_pkg
